//--- logic/smrc_pkg.sv
// Package with register map, field positions, reset values and shared types of the supply monitor.
package smrc_pkg;

  // ==========================================================================
  // Register map (indices; the byte address is four times the index)
  // ==========================================================================
  localparam int unsigned SMRC_IDX_W = 8;
  localparam logic [SMRC_IDX_W-1:0] SMRC_IDX_IRQ_MASK = 8'h0e;
  localparam logic [SMRC_IDX_W-1:0] SMRC_IDX_IRQ_STATUS = 8'h0f;
  localparam logic [SMRC_IDX_W-1:0] SMRC_IDX_REGULATOR = 8'h10;
  localparam logic [SMRC_IDX_W-1:0] SMRC_IDX_BATTERY = 8'h11;
  localparam int unsigned SMRC_ADR_LSB = 2;
  localparam int unsigned SMRC_REG_W = 8;

  // ==========================================================================
  // Field positions
  // ==========================================================================
  localparam int unsigned SMRC_REG_ANALOG_EXT = 7;
  localparam int unsigned SMRC_REG_ANALOG_OK = 6;
  localparam int unsigned SMRC_REG_SPARE_HI = 4;
  localparam int unsigned SMRC_REG_DIGITAL_EXT = 3;
  localparam int unsigned SMRC_REG_DIGITAL_OK = 2;
  localparam int unsigned SMRC_REG_SPARE_LO = 0;
  localparam int unsigned SMRC_BAT_OK = 5;
  localparam int unsigned SMRC_BAT_HIGH_RANGE = 4;
  localparam int unsigned SMRC_BAT_THRESHOLD = 0;
  localparam int unsigned SMRC_THRESHOLD_W = 4;
  localparam int unsigned SMRC_IRQ_LOW_BATTERY = 7;

  // ==========================================================================
  // Reset values
  // ==========================================================================
  localparam logic [1:0] SMRC_SPARE_RST = 2'h0;
  localparam logic SMRC_EXT_RST = 1'b0;
  localparam logic [SMRC_THRESHOLD_W-1:0] SMRC_THRESHOLD_RST = 4'h2;
  localparam logic SMRC_HIGH_RANGE_RST = 1'b0;
  localparam logic [SMRC_REG_W-1:0] SMRC_IRQ_MASK_RST = 8'h00;

  // ==========================================================================
  // Transceiver states in which the battery monitor sleeps
  // ==========================================================================
  localparam logic [4:0] SMRC_TRX_POWER_ON = 5'h00;
  localparam logic [4:0] SMRC_TRX_SLEEP = 5'h0f;

  // ==========================================================================
  // Threshold scale in millivolts
  // ==========================================================================
  localparam int unsigned SMRC_MV_W = 12;
  localparam logic [SMRC_MV_W-1:0] SMRC_LOW_BASE_MV = 12'h6a4;
  localparam logic [SMRC_MV_W-1:0] SMRC_LOW_STEP_MV = 12'h032;
  localparam logic [SMRC_MV_W-1:0] SMRC_HIGH_BASE_MV = 12'h9f6;
  localparam logic [SMRC_MV_W-1:0] SMRC_HIGH_STEP_MV = 12'h04b;

  // ==========================================================================
  // Types
  // ==========================================================================
  typedef struct packed {
    logic analog_ext;
    logic [1:0] spare_hi;
    logic digital_ext;
    logic [1:0] spare_lo;
  } smrc_regulator_cfg_t;

  typedef struct packed {
    logic high_range;
    logic [SMRC_THRESHOLD_W-1:0] threshold;
  } smrc_battery_cfg_t;

  typedef struct packed {
    logic battery_above;
    logic analog_stable;
    logic digital_stable;
  } smrc_supply_sense_t;

  typedef enum logic [1:0] {
    SMRC_MON_IDLE = 2'b01,
    SMRC_MON_ACTIVE = 2'b10
  } smrc_mon_state_t;

endpackage : smrc_pkg

//--- logic/smrc_sync.sv
// Two-flop synchroniser bank for asynchronous analog sense levels.
`timescale 1ns/1ps
`default_nettype none
module smrc_sync #(
  parameter int unsigned WIDTH = 3
) (
  input wire logic mclk_i,
  input wire logic rst_b_i,
  input wire logic ce_i,
  input wire logic [WIDTH-1:0] async_i,
  output logic [WIDTH-1:0] sync_o
);

  logic [WIDTH-1:0] meta;

  // ==========================================================================
  // One synchroniser per bit; the first flop feeds only the second.
  // ==========================================================================
  for (genvar gi = 0; gi < WIDTH; gi++) begin : g_bit
    always_ff @(posedge mclk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
        meta[gi] <= 1'b0;
        sync_o[gi] <= 1'b0;
      end else if (ce_i) begin
        meta[gi] <= async_i[gi];
        sync_o[gi] <= meta[gi];
      end
    end
  end

endmodule : smrc_sync
`default_nettype wire

//--- logic/smrc_threshold.sv
// Decoder from the threshold code and range select to the threshold in millivolts.
`timescale 1ns/1ps
`default_nettype none
module smrc_threshold (
  input wire smrc_pkg::smrc_battery_cfg_t cfg_i,
  output logic [smrc_pkg::SMRC_MV_W-1:0] mv_o
);

  logic [smrc_pkg::SMRC_MV_W-1:0] code;

  assign code = {{(smrc_pkg::SMRC_MV_W - smrc_pkg::SMRC_THRESHOLD_W){1'b0}}, cfg_i.threshold};

  // ==========================================================================
  // Linear scale; the two ranges together span 1700 mV to 3675 mV.
  // ==========================================================================
  always_comb begin
    if (cfg_i.high_range) begin
      mv_o = smrc_pkg::SMRC_MV_W'(smrc_pkg::SMRC_HIGH_BASE_MV + code * smrc_pkg::SMRC_HIGH_STEP_MV);
    end else begin
      mv_o = smrc_pkg::SMRC_MV_W'(smrc_pkg::SMRC_LOW_BASE_MV + code * smrc_pkg::SMRC_LOW_STEP_MV);
    end
  end

endmodule : smrc_threshold
`default_nettype wire

//--- logic/smrc_top.sv
// Supply monitor and regulator control with a classic Wishbone register slave.
//
// Behaviour
// - The regulator configuration register sits at register index 0x10.
// - Setting both external-supply selects turns both internal regulators off.
// - Bit 3 of the regulator register selects an external digital supply and resets to 0.
// - Bit 7 of the regulator register selects an external analog supply and resets to 0.
// - Bits 6 and 2 read 1 only while the analog or digital internal regulator is on and stable.
// - The battery monitor register sits at register index 0x11.
// - The monitor compares the external supply against the threshold chosen by the threshold field.
// - The threshold steps by 75 mV in the high range and by 50 mV in the low range.
// - The threshold spans 1.7 V at its lowest to 3.675 V at its highest setting.
// - The battery-ok bit reads 0 while the supply is below the threshold and 1 while above.
// - The low-battery interrupt, number 7, is raised only on a 1 to 0 change of battery-ok.
// - A supply that is low from power-up, so battery-ok was never 1, raises no interrupt.
// - Writing a threshold still above the supply raises no interrupt as battery-ok stays 0.
// - The monitor neither updates status nor raises interrupts in power-on or sleep state.
//
// Our own choice: the Wishbone interface to the registers.
`timescale 1ns/1ps
`default_nettype none
module smrc_top #(
  parameter int unsigned ADR_W = 10
) (
  input wire logic mclk_i,
  input wire logic rst_b_i,
  input wire logic ce_i,
  // Wishbone classic slave.
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [ADR_W-1:0] wb_adr_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // Analog sense and control.
  input wire logic battery_above_i,
  input wire logic analog_regulator_stable_i,
  input wire logic digital_regulator_stable_i,
  input wire logic [4:0] transceiver_state_i,
  output logic analog_regulator_enable_o,
  output logic digital_regulator_enable_o,
  output logic [smrc_pkg::SMRC_THRESHOLD_W-1:0] battery_threshold_field_o,
  output logic battery_high_range_select_o,
  output logic [smrc_pkg::SMRC_MV_W-1:0] battery_threshold_mv_o,
  output logic battery_monitor_enable_o,
  output logic irq_o
);

  // ==========================================================================
  // Declarations
  // ==========================================================================
  smrc_pkg::smrc_regulator_cfg_t regulator_cfg;
  smrc_pkg::smrc_battery_cfg_t battery_cfg;
  smrc_pkg::smrc_supply_sense_t sense_raw;
  smrc_pkg::smrc_supply_sense_t sense_sync;
  smrc_pkg::smrc_mon_state_t mon_state;
  smrc_pkg::smrc_mon_state_t next_mon_state;
  logic [smrc_pkg::SMRC_IDX_W-1:0] bus_idx;
  logic bus_take;
  logic bus_write;
  logic wr_regulator;
  logic wr_battery;
  logic wr_irq_mask;
  logic wr_irq_status;
  logic [7:0] wr_byte;
  logic [7:0] irq_status;
  logic [7:0] irq_mask;
  logic [7:0] irq_set;
  logic [7:0] irq_clear;
  logic [7:0] next_irq_status;
  logic [7:0] regulator_read;
  logic [7:0] battery_read;
  logic [31:0] next_rd_data;
  logic battery_ok_status;
  logic battery_falling;
  logic transceiver_quiet;
  logic analog_supply_stable;
  logic digital_supply_stable;
  logic [smrc_pkg::SMRC_MV_W-1:0] threshold_mv;

  // ==========================================================================
  // Synchronisation of analog sense levels
  // ==========================================================================
  assign sense_raw.battery_above = battery_above_i;
  assign sense_raw.analog_stable = analog_regulator_stable_i;
  assign sense_raw.digital_stable = digital_regulator_stable_i;

  smrc_sync #(
    .WIDTH(3)
  ) u_sync (
    .mclk_i(mclk_i),
    .rst_b_i(rst_b_i),
    .ce_i(ce_i),
    .async_i(sense_raw),
    .sync_o(sense_sync)
  );

  // ==========================================================================
  // Threshold decode
  // ==========================================================================
  smrc_threshold u_threshold (
    .cfg_i(battery_cfg),
    .mv_o(threshold_mv)
  );

  // ==========================================================================
  // Wishbone decode
  // ==========================================================================
  assign bus_idx = wb_adr_i[smrc_pkg::SMRC_ADR_LSB +: smrc_pkg::SMRC_IDX_W];
  assign bus_take = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign bus_write = bus_take && wb_we_i && wb_sel_i[0];
  assign wr_byte = wb_dat_i[7:0];

  // A request is answered one cycle after it is seen, also at unmapped indices.
  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      wb_ack_o <= 1'b0;
    end else if (ce_i) begin
      wb_ack_o <= bus_take;
    end
  end

  // ==========================================================================
  // Register write strobes
  // ==========================================================================
  // One strobe at most per taken write; sel[0] low or an unmapped index
  // raises none, so such writes are dropped.
  always_comb begin
    wr_regulator = 1'b0;
    wr_battery = 1'b0;
    wr_irq_mask = 1'b0;
    wr_irq_status = 1'b0;
    if (bus_write) begin
      if (bus_idx == smrc_pkg::SMRC_IDX_REGULATOR) begin
        wr_regulator = 1'b1;
      end else if (bus_idx == smrc_pkg::SMRC_IDX_BATTERY) begin
        wr_battery = 1'b1;
      end else if (bus_idx == smrc_pkg::SMRC_IDX_IRQ_MASK) begin
        wr_irq_mask = 1'b1;
      end else if (bus_idx == smrc_pkg::SMRC_IDX_IRQ_STATUS) begin
        wr_irq_status = 1'b1;
      end
    end
  end

  // ==========================================================================
  // Regulator control register
  // ==========================================================================
  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      regulator_cfg.analog_ext <= smrc_pkg::SMRC_EXT_RST;
      regulator_cfg.spare_hi <= smrc_pkg::SMRC_SPARE_RST;
      regulator_cfg.digital_ext <= smrc_pkg::SMRC_EXT_RST;
      regulator_cfg.spare_lo <= smrc_pkg::SMRC_SPARE_RST;
    end else if (ce_i) begin
      if (wr_regulator) begin
        regulator_cfg.analog_ext <= wr_byte[smrc_pkg::SMRC_REG_ANALOG_EXT];
        regulator_cfg.spare_hi <= wr_byte[smrc_pkg::SMRC_REG_SPARE_HI +: 2];
        regulator_cfg.digital_ext <= wr_byte[smrc_pkg::SMRC_REG_DIGITAL_EXT];
        regulator_cfg.spare_lo <= wr_byte[smrc_pkg::SMRC_REG_SPARE_LO +: 2];
      end
    end
  end

  // Each internal regulator runs unless its external select is set.
  assign analog_regulator_enable_o = !regulator_cfg.analog_ext;
  assign digital_regulator_enable_o = !regulator_cfg.digital_ext;

  // Stable is reported only for an enabled internal regulator.
  assign analog_supply_stable = !regulator_cfg.analog_ext && sense_sync.analog_stable;
  assign digital_supply_stable = !regulator_cfg.digital_ext && sense_sync.digital_stable;

  always_comb begin
    regulator_read = 8'h00;
    regulator_read[smrc_pkg::SMRC_REG_ANALOG_EXT] = regulator_cfg.analog_ext;
    regulator_read[smrc_pkg::SMRC_REG_ANALOG_OK] = analog_supply_stable;
    regulator_read[smrc_pkg::SMRC_REG_SPARE_HI +: 2] = regulator_cfg.spare_hi;
    regulator_read[smrc_pkg::SMRC_REG_DIGITAL_EXT] = regulator_cfg.digital_ext;
    regulator_read[smrc_pkg::SMRC_REG_DIGITAL_OK] = digital_supply_stable;
    regulator_read[smrc_pkg::SMRC_REG_SPARE_LO +: 2] = regulator_cfg.spare_lo;
  end

  // ==========================================================================
  // Battery monitor configuration
  // ==========================================================================
  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      battery_cfg.high_range <= smrc_pkg::SMRC_HIGH_RANGE_RST;
      battery_cfg.threshold <= smrc_pkg::SMRC_THRESHOLD_RST;
    end else if (ce_i) begin
      if (wr_battery) begin
        battery_cfg.high_range <= wr_byte[smrc_pkg::SMRC_BAT_HIGH_RANGE];
        battery_cfg.threshold <= wr_byte[smrc_pkg::SMRC_BAT_THRESHOLD +: smrc_pkg::SMRC_THRESHOLD_W];
      end
    end
  end

  assign battery_threshold_field_o = battery_cfg.threshold;
  assign battery_high_range_select_o = battery_cfg.high_range;

  // The threshold in millivolts is registered for the comparator reference.
  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      battery_threshold_mv_o <= smrc_pkg::SMRC_LOW_BASE_MV;
    end else if (ce_i) begin
      battery_threshold_mv_o <= threshold_mv;
    end
  end

  // ==========================================================================
  // Monitor activity state
  // ==========================================================================
  assign transceiver_quiet = (transceiver_state_i == smrc_pkg::SMRC_TRX_POWER_ON) ||
                             (transceiver_state_i == smrc_pkg::SMRC_TRX_SLEEP);

  always_comb begin
    next_mon_state = mon_state;
    case (mon_state)
      smrc_pkg::SMRC_MON_IDLE: begin
        if (!transceiver_quiet) begin
          next_mon_state = smrc_pkg::SMRC_MON_ACTIVE;
        end
      end
      smrc_pkg::SMRC_MON_ACTIVE: begin
        if (transceiver_quiet) begin
          next_mon_state = smrc_pkg::SMRC_MON_IDLE;
        end
      end
      default: begin
        next_mon_state = smrc_pkg::SMRC_MON_IDLE;
      end
    endcase
  end

  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      mon_state <= smrc_pkg::SMRC_MON_IDLE;
    end else if (ce_i) begin
      mon_state <= next_mon_state;
    end
  end

  assign battery_monitor_enable_o = (mon_state == smrc_pkg::SMRC_MON_ACTIVE);

  // ==========================================================================
  // Battery-ok status
  // ==========================================================================
  // The status holds its last value while the monitor is idle, so a supply that
  // sank during sleep is reported once the monitor wakes.
  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      battery_ok_status <= 1'b0;
    end else if (ce_i) begin
      if (battery_monitor_enable_o) begin
        battery_ok_status <= sense_sync.battery_above;
      end
    end
  end

  // Only a 1 to 0 change counts; a status that stays 0 after a threshold write
  // or from power-up never produces this pulse.
  assign battery_falling = battery_monitor_enable_o && battery_ok_status &&
                           !sense_sync.battery_above;

  always_comb begin
    battery_read = 8'h00;
    battery_read[smrc_pkg::SMRC_BAT_OK] = battery_ok_status;
    battery_read[smrc_pkg::SMRC_BAT_HIGH_RANGE] = battery_cfg.high_range;
    battery_read[smrc_pkg::SMRC_BAT_THRESHOLD +: smrc_pkg::SMRC_THRESHOLD_W] = battery_cfg.threshold;
  end

  // ==========================================================================
  // Interrupt status and mask
  // ==========================================================================
  always_comb begin
    irq_set = 8'h00;
    irq_set[smrc_pkg::SMRC_IRQ_LOW_BATTERY] = battery_falling;
  end

  assign irq_clear = wr_irq_status ? wr_byte : 8'h00;

  // The output flop reads the next status, so the pin moves with the bit.
  assign next_irq_status = (irq_status & ~irq_clear) | irq_set;

  // A new event wins over a write-one clear in the same cycle.
  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      irq_status <= 8'h00;
    end else if (ce_i) begin
      irq_status <= next_irq_status;
    end
  end

  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      irq_mask <= smrc_pkg::SMRC_IRQ_MASK_RST;
    end else if (ce_i) begin
      if (wr_irq_mask) begin
        irq_mask <= wr_byte;
      end
    end
  end

  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      irq_o <= 1'b0;
    end else if (ce_i) begin
      irq_o <= |(next_irq_status & irq_mask);
    end
  end

  // ==========================================================================
  // Read data
  // ==========================================================================
  always_comb begin
    next_rd_data = 32'h0000_0000;
    if (bus_idx == smrc_pkg::SMRC_IDX_REGULATOR) begin
      next_rd_data[7:0] = regulator_read;
    end else if (bus_idx == smrc_pkg::SMRC_IDX_BATTERY) begin
      next_rd_data[7:0] = battery_read;
    end else if (bus_idx == smrc_pkg::SMRC_IDX_IRQ_STATUS) begin
      next_rd_data[7:0] = irq_status;
    end else if (bus_idx == smrc_pkg::SMRC_IDX_IRQ_MASK) begin
      next_rd_data[7:0] = irq_mask;
    end
  end

  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      wb_dat_o <= 32'h0000_0000;
    end else if (ce_i) begin
      if (bus_take && !wb_we_i) begin
        wb_dat_o <= next_rd_data;
      end
    end
  end

endmodule : smrc_top
`default_nettype wire

//--- tb/smrc_chk.sv
// Checker with concurrent assertions on the ports of the supply monitor.
`timescale 1ns/1ps
`default_nettype none
module smrc_chk #(
  parameter int unsigned ADR_W = 10
) (
  input wire logic mclk_i,
  input wire logic rst_b_i,
  input wire logic ce_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [ADR_W-1:0] wb_adr_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic wb_ack_o,
  input wire logic battery_above_i,
  input wire logic [4:0] transceiver_state_i,
  input wire logic analog_regulator_enable_o,
  input wire logic digital_regulator_enable_o,
  input wire logic [smrc_pkg::SMRC_THRESHOLD_W-1:0] battery_threshold_field_o,
  input wire logic battery_high_range_select_o,
  input wire logic [smrc_pkg::SMRC_MV_W-1:0] battery_threshold_mv_o,
  input wire logic battery_monitor_enable_o,
  input wire logic irq_o
);
  // ==========================================================================
  // Helper logic
  // ==========================================================================
  logic [7:0] idx;
  logic [11:0] exp_mv;
  assign idx = wb_adr_i[smrc_pkg::SMRC_ADR_LSB +: 8];
  assign exp_mv = battery_high_range_select_o ?
    smrc_pkg::SMRC_HIGH_BASE_MV + smrc_pkg::SMRC_HIGH_STEP_MV * battery_threshold_field_o :
    smrc_pkg::SMRC_LOW_BASE_MV + smrc_pkg::SMRC_LOW_STEP_MV * battery_threshold_field_o;
  // ==========================================================================
  // Assertions
  // ==========================================================================
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!rst_b_i);
  sequence s_take;
    wb_cyc_i && wb_stb_i && !wb_ack_o && ce_i;
  endsequence
  sequence s_wr(i);
    s_take ##0 (wb_we_i && wb_sel_i[0] && idx == i);
  endsequence
  AST_ACK_LATENCY: assert property (s_take |=> wb_ack_o)
    else $error("Bus request was not answered in the next cycle.");
  AST_ACK_PULSE: assert property ((wb_ack_o && ce_i) |=> !wb_ack_o)
    else $error("Bus answer lasted more than one cycle.");
  AST_ANALOG_SEL: assert property (s_wr(8'h10) |=> analog_regulator_enable_o == !$past(wb_dat_i[7]))
    else $error("Analog regulator enable does not follow the written select.");
  AST_DIGITAL_SEL: assert property (s_wr(8'h10) |=> digital_regulator_enable_o == !$past(wb_dat_i[3]))
    else $error("Digital regulator enable does not follow the written select.");
  AST_BOTH_OFF: assert property ((s_wr(8'h10) ##0 (wb_dat_i[7] && wb_dat_i[3]))
    |=> !analog_regulator_enable_o && !digital_regulator_enable_o)
    else $error("Internal regulators not both off after both external selects.");
  AST_THRESHOLD: assert property (s_wr(8'h11) |=> battery_threshold_field_o == $past(wb_dat_i[3:0])
    && battery_high_range_select_o == $past(wb_dat_i[4]))
    else $error("Threshold field or range does not hold the written value.");
  AST_MV: assert property ((rst_b_i && ce_i) |=> battery_threshold_mv_o == $past(exp_mv))
    else $error("Threshold in millivolts does not match the code and range.");
  AST_MON_QUIET: assert property ((rst_b_i && ce_i) |=> battery_monitor_enable_o ==
    ($past(transceiver_state_i) != 5'h00 && $past(transceiver_state_i) != 5'h0f))
    else $error("Monitor enable does not follow the transceiver state.");
  AST_IRQ_RISE: assert property ($rose(irq_o) |-> !$past(battery_above_i) || $past(wb_we_i)
    || $past(wb_we_i, 2))
    else $error("Interrupt rose with the supply high and no register write.");
  AST_IRQ_FALL: assert property ($fell(irq_o) |-> $past(wb_we_i) || $past(wb_we_i, 2))
    else $error("Interrupt fell without a register write.");
endmodule : smrc_chk
`default_nettype wire

//--- tb/tb.sv
// Self-checking testbench of the supply monitor and regulator control.
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic mclk_i, rst_b_i, cyc, stb, we, bat, astab, dstab, ack, irq, aen, den, hr, mon;
  logic [3:0] sel;
  logic [3:0] fld;
  logic [9:0] adr;
  logic [31:0] wdat, rdo;
  logic [4:0] state;
  logic [11:0] mv;
  int failures, checked;

  smrc_top dut (.mclk_i(mclk_i), .rst_b_i(rst_b_i), .ce_i(1'b1), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_sel_i(sel), .wb_adr_i(adr), .wb_dat_i(wdat), .wb_dat_o(rdo), .wb_ack_o(ack),
    .battery_above_i(bat), .analog_regulator_stable_i(astab), .digital_regulator_stable_i(dstab),
    .transceiver_state_i(state), .analog_regulator_enable_o(aen), .digital_regulator_enable_o(den),
    .battery_threshold_field_o(fld), .battery_high_range_select_o(hr), .battery_threshold_mv_o(mv),
    .battery_monitor_enable_o(mon), .irq_o(irq));

  // ==========================================================================
  // Shared tasks
  // ==========================================================================
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      failures++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  // One classic cycle; the request holds until ack is sampled, then idles for a cycle.
  task automatic bus(input logic w, input logic [7:0] idx, input logic [7:0] d, output logic [7:0] q);
    int n;
    n = 0;
    cyc <= 1'b1; stb <= 1'b1; we <= w; sel <= 4'hf; adr <= {idx, 2'b00}; wdat <= {24'h0, d};
    do begin
      @(posedge mclk_i);
      n++;
    end while (ack !== 1'b1 && n < 50);
    if (n >= 50) chk("bus_ack", ack, 1'b1);
    q = rdo[7:0];
    cyc <= 1'b0; stb <= 1'b0; we <= 1'b0;
    @(posedge mclk_i);
  endtask : bus

  task automatic wr(input logic [7:0] idx, input logic [7:0] d);
    logic [7:0] q;
    bus(1'b1, idx, d, q);
  endtask : wr

  task automatic rd(input logic [7:0] idx, input logic [7:0] exp);
    logic [7:0] q;
    bus(1'b0, idx, 8'h00, q);
    chk($sformatf("reg_%h", idx), q, exp);
  endtask : rd

  task automatic wait_irq(input logic v);
    int n;
    n = 0;
    while (irq !== v && n < 20) begin
      @(posedge mclk_i);
      n++;
    end
    chk("irq", irq, v);
  endtask : wait_irq

  // ==========================================================================
  // Scenarios
  // ==========================================================================
  task automatic t_reset();
    chk("aen", aen, 1'b1);
    chk("den", den, 1'b1);
    chk("mv", mv, 32'd1800);
    chk("irq", irq, 1'b0);
    rd(8'h10, 8'h44);
    rd(8'h11, 8'h02);
    rd(8'h0f, 8'h00);
    wr(8'h20, 8'hff);
    rd(8'h20, 8'h00);
    $display("test reset done");
  endtask : t_reset

  task automatic t_regulator();
    wr(8'h10, 8'h88);
    chk("aen", aen, 1'b0);
    chk("den", den, 1'b0);
    rd(8'h10, 8'h88);
    wr(8'h10, 8'h38);
    rd(8'h10, 8'h78);
    wr(8'h10, 8'h00);
    dstab <= 1'b0;
    repeat (3) @(posedge mclk_i);
    rd(8'h10, 8'h40);
    dstab <= 1'b1;
    $display("test regulator done");
  endtask : t_regulator

  task automatic t_threshold();
    for (int r = 0; r < 2; r++) begin
      for (int c = 0; c < 16; c++) begin
        wr(8'h11, 8'((r << 4) | c));
        chk("fld", fld, 32'(c));
        chk("hr", hr, r[0]);
        chk("mv", mv, r ? 32'(2550 + 75 * c) : 32'(1700 + 50 * c));
        rd(8'h11, 8'((r << 4) | c));
      end
    end
    chk("irq", irq, 1'b0);
    wr(8'h11, 8'h02);
    $display("test threshold done");
  endtask : t_threshold

  task automatic t_battery();
    wr(8'h0e, 8'h80);
    bat <= 1'b1;
    repeat (4) @(posedge mclk_i);
    rd(8'h11, 8'h22);
    chk("irq", irq, 1'b0);
    bat <= 1'b0;
    wait_irq(1'b1);
    rd(8'h0f, 8'h80);
    rd(8'h11, 8'h02);
    wr(8'h0f, 8'h80);
    wait_irq(1'b0);
    wr(8'h0e, 8'h00);
    bat <= 1'b1;
    repeat (4) @(posedge mclk_i);
    bat <= 1'b0;
    repeat (6) @(posedge mclk_i);
    chk("irq", irq, 1'b0);
    rd(8'h0f, 8'h80);
    wr(8'h0e, 8'h80);
    wait_irq(1'b1);
    wr(8'h0f, 8'h80);
    wait_irq(1'b0);
    $display("test battery done");
  endtask : t_battery

  task automatic t_sleep();
    state <= 5'h0f;
    bat <= 1'b1;
    repeat (6) @(posedge mclk_i);
    chk("mon", mon, 1'b0);
    rd(8'h11, 8'h02);
    state <= 5'h08;
    repeat (5) @(posedge mclk_i);
    rd(8'h11, 8'h22);
    state <= 5'h00;
    bat <= 1'b0;
    repeat (6) @(posedge mclk_i);
    chk("irq", irq, 1'b0);
    rd(8'h0f, 8'h00);
    state <= 5'h08;
    wait_irq(1'b1);
    wr(8'h0f, 8'h80);
    wait_irq(1'b0);
    $display("test sleep done");
  endtask : t_sleep

  task automatic conclude();
    $display("checked %0d failures %0d", checked, failures);
    if (failures == 0 && checked > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : conclude

  // ==========================================================================
  // Clock, reset, sequence and watchdog
  // ==========================================================================
  initial begin
    mclk_i = 1'b0;
    forever #2.5 mclk_i = ~mclk_i;
  end

  initial begin
    rst_b_i = 1'b0; cyc = 1'b0; stb = 1'b0; we = 1'b0; sel = 4'h0; adr = 10'h000; wdat = 32'h0;
    bat = 1'b0; astab = 1'b1; dstab = 1'b1; state = 5'h08; failures = 0; checked = 0;
    repeat (2) @(posedge mclk_i);
    rst_b_i <= 1'b1;
    repeat (3) @(posedge mclk_i);
    t_reset();
    t_regulator();
    t_threshold();
    t_battery();
    t_sleep();
    conclude();
  end

  initial begin
    #100000;
    failures++;
    conclude();
  end
endmodule : tb

bind smrc_top smrc_chk #(.ADR_W(ADR_W)) u_chk (.mclk_i(mclk_i), .rst_b_i(rst_b_i), .ce_i(ce_i),
  .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_sel_i(wb_sel_i), .wb_adr_i(wb_adr_i),
  .wb_dat_i(wb_dat_i), .wb_ack_o(wb_ack_o), .battery_above_i(battery_above_i),
  .transceiver_state_i(transceiver_state_i), .analog_regulator_enable_o(analog_regulator_enable_o),
  .digital_regulator_enable_o(digital_regulator_enable_o), .battery_threshold_field_o(battery_threshold_field_o),
  .battery_high_range_select_o(battery_high_range_select_o), .battery_threshold_mv_o(battery_threshold_mv_o),
  .battery_monitor_enable_o(battery_monitor_enable_o), .irq_o(irq_o));
`default_nettype wire
